// ==== inc/tcpu_pkg.sv ====
// Purpose: Constants and types shared by the timer/counter/PWM array.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes: Unit n occupies a 32-byte window at n times the unit stride.
package tcpu_pkg;
    localparam int TCPU_UNITS = 8;
    localparam int TCPU_CNT_W = 16;
    localparam int TCPU_DB_W = 8;
    localparam int TCPU_ADDR_W = 9;
    localparam int TCPU_CTRL_W = 3;
    localparam int TCPU_EVT_W = 2 * TCPU_UNITS;
    localparam int TCPU_EVT_CAP_BASE = TCPU_UNITS;

    // Address fields: bit 8 selects the global block, 7:5 the unit.
    localparam int TCPU_GLOBAL_BIT = 8;
    localparam int TCPU_UNIT_MSB = 7;
    localparam int TCPU_UNIT_LSB = 5;
    localparam int TCPU_OFS_MSB = 4;

    // Per-unit register offsets inside the unit window.
    localparam logic [4:0] TCPU_OFS_CTRL = 5'h00;
    localparam logic [4:0] TCPU_OFS_PERIOD = 5'h04;
    localparam logic [4:0] TCPU_OFS_COMPARE = 5'h08;
    localparam logic [4:0] TCPU_OFS_DEADBAND = 5'h0C;
    localparam logic [4:0] TCPU_OFS_CAPTURE = 5'h10;
    localparam logic [4:0] TCPU_OFS_COUNT = 5'h14;

    // Global interrupt registers.
    localparam logic [8:0] TCPU_ADDR_IRQ_STATUS = 9'h100;
    localparam logic [8:0] TCPU_ADDR_IRQ_MASK = 9'h104;

    // Control bits.
    localparam int TCPU_CTRL_EN_BIT = 0;
    localparam int TCPU_CTRL_ONESHOT_BIT = 1;
    localparam int TCPU_CTRL_CAPEN_BIT = 2;

    // Reset values.
    localparam logic [2:0] TCPU_CTRL_RST = 3'h0;
    localparam logic [15:0] TCPU_PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] TCPU_COMPARE_RST = 16'h0000;
    localparam logic [15:0] TCPU_CNT_RST = 16'h0000;
    localparam logic [15:0] TCPU_CNT_ONE = 16'h0001;
    localparam logic [7:0] TCPU_DB_RST = 8'h00;
    localparam logic [7:0] TCPU_DB_ONE = 8'h01;
    localparam logic [15:0] TCPU_EVT_RST = 16'h0000;
    localparam logic [31:0] TCPU_WORD_ZERO = 32'h00000000;
    localparam logic [7:0] TCPU_LANE_ONES = 8'hFF;
    localparam logic [7:0] TCPU_LANE_ZERO = 8'h00;
    localparam logic [1:0] TCPU_ALIGN_OK = 2'h0;

    // Level both outputs take while kill is asserted.
    localparam logic TCPU_KILL_LEVEL = 1'b0;

    typedef struct packed {
        logic [TCPU_UNITS-1:0][TCPU_CTRL_W-1:0] ctrl;
        logic [TCPU_UNITS-1:0][TCPU_CNT_W-1:0] period;
        logic [TCPU_UNITS-1:0][TCPU_CNT_W-1:0] compare;
        logic [TCPU_UNITS-1:0][TCPU_DB_W-1:0] dead_cfg;
        logic [TCPU_UNITS-1:0][TCPU_CNT_W-1:0] cnt;
        logic [TCPU_UNITS-1:0][TCPU_CNT_W-1:0] capture;
        logic [TCPU_UNITS-1:0][TCPU_DB_W-1:0] dead_cnt;
        logic [TCPU_UNITS-1:0] raw;
        logic [TCPU_UNITS-1:0] out_p;
        logic [TCPU_UNITS-1:0] out_n;
        logic [TCPU_UNITS-1:0] kill_s1;
        logic [TCPU_UNITS-1:0] kill_s2;
        logic [TCPU_UNITS-1:0] cap_s1;
        logic [TCPU_UNITS-1:0] cap_s2;
        logic [TCPU_UNITS-1:0] cap_d;
        logic [TCPU_EVT_W-1:0] irq_status;
        logic [TCPU_EVT_W-1:0] irq_mask;
        logic irq;
        logic wait_req;
        logic [31:0] readdata;
    } tcpu_state_s;
endpackage

// ==== verilog/tcpu_top.sv ====
// Purpose: Eight 16-bit timer/counter/PWM units behind an Avalon-MM slave.
// Assumes: Kill and capture pins are asynchronous to core_clk.
// Notes: Every access takes one wait cycle; writes land on the final edge.
`timescale 1ns/10ps
`default_nettype none
module tcpu_top (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [tcpu_pkg::TCPU_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [tcpu_pkg::TCPU_UNITS-1:0] kill_in,
    input wire logic [tcpu_pkg::TCPU_UNITS-1:0] capture_in,
    output logic [tcpu_pkg::TCPU_UNITS-1:0] pwm_out,
    output logic [tcpu_pkg::TCPU_UNITS-1:0] pwm_n_out,
    output logic irq
);
    import tcpu_pkg::*;

    // Register picked by an access; unmapped and unaligned both map to
    // none so reads return zero and writes fall through harmlessly.
    typedef enum {
        TCPU_REG_NONE,
        TCPU_REG_STATUS,
        TCPU_REG_MASK,
        TCPU_REG_CTRL,
        TCPU_REG_PERIOD,
        TCPU_REG_COMPARE,
        TCPU_REG_DEADBAND,
        TCPU_REG_CAPTURE,
        TCPU_REG_COUNT
    } tcpu_reg_e;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Expands the byte enables into a bit mask.
    function automatic logic [31:0] tcpu_lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = TCPU_WORD_ZERO;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = be[b] ? TCPU_LANE_ONES : TCPU_LANE_ZERO;
        end
        return m;
    endfunction

    // True when the address hits the given offset of a unit window.
    function automatic logic tcpu_hit(input logic [TCPU_ADDR_W-1:0] a,
                                      input logic [4:0] ofs);
        return !a[TCPU_GLOBAL_BIT] && (a[TCPU_OFS_MSB:0] == ofs);
    endfunction

    // One decoder serves both the read mux and the write path so the two
    // can never disagree about which register an address selects.
    function automatic tcpu_reg_e tcpu_decode(
            input logic [TCPU_ADDR_W-1:0] a);
        tcpu_reg_e r;
        r = TCPU_REG_NONE;
        if (a[1:0] != TCPU_ALIGN_OK) begin
            r = TCPU_REG_NONE;
        end else if (a == TCPU_ADDR_IRQ_STATUS) begin
            r = TCPU_REG_STATUS;
        end else if (a == TCPU_ADDR_IRQ_MASK) begin
            r = TCPU_REG_MASK;
        end else if (tcpu_hit(a, TCPU_OFS_CTRL)) begin
            r = TCPU_REG_CTRL;
        end else if (tcpu_hit(a, TCPU_OFS_PERIOD)) begin
            r = TCPU_REG_PERIOD;
        end else if (tcpu_hit(a, TCPU_OFS_COMPARE)) begin
            r = TCPU_REG_COMPARE;
        end else if (tcpu_hit(a, TCPU_OFS_DEADBAND)) begin
            r = TCPU_REG_DEADBAND;
        end else if (tcpu_hit(a, TCPU_OFS_CAPTURE)) begin
            r = TCPU_REG_CAPTURE;
        end else if (tcpu_hit(a, TCPU_OFS_COUNT)) begin
            r = TCPU_REG_COUNT;
        end
        return r;
    endfunction

    // Byte-lane merge shared by the 16-bit mask, period and compare registers.
    function automatic logic [TCPU_CNT_W-1:0] tcpu_merge16(
            input logic [TCPU_CNT_W-1:0] old_v,
            input logic [31:0] new_v,
            input logic [31:0] m);
        return (old_v & ~m[TCPU_CNT_W-1:0]) |
            (new_v[TCPU_CNT_W-1:0] & m[TCPU_CNT_W-1:0]);
    endfunction

    // One counter step. A one-shot halt leaves the count parked on the
    // period so software can read where the unit stopped.
    function automatic logic [TCPU_CNT_W-1:0] tcpu_count_step(
            input logic [TCPU_CNT_W-1:0] cnt,
            input logic [TCPU_CNT_W-1:0] period,
            input logic oneshot);
        logic [TCPU_CNT_W-1:0] n;
        n = cnt + TCPU_CNT_ONE;
        if (cnt == period) begin
            n = oneshot ? cnt : TCPU_CNT_RST;
        end
        return n;
    endfunction

    // Dead-band counter of one unit: reload on every change of the raw
    // compare level, then run down to zero and rest there.
    function automatic logic [TCPU_DB_W-1:0] tcpu_dead_step(
            input logic changed,
            input logic [TCPU_DB_W-1:0] dead,
            input logic [TCPU_DB_W-1:0] cfg);
        logic [TCPU_DB_W-1:0] n;
        n = dead;
        if (changed) begin
            n = cfg;
        end else if (dead != TCPU_DB_RST) begin
            n = dead - TCPU_DB_ONE;
        end
        return n;
    endfunction

    // Output pair of one unit. Kill wins over everything so the switches
    // open even while the counter keeps running underneath.
    function automatic logic [1:0] tcpu_drive(input logic kill,
            input logic raw, input logic en,
            input logic [TCPU_DB_W-1:0] dead);
        logic [1:0] pn;
        pn = {TCPU_KILL_LEVEL, TCPU_KILL_LEVEL};
        if (!kill) begin
            pn[1] = raw && (dead == TCPU_DB_RST);
            pn[0] = !raw && en && (dead == TCPU_DB_RST);
        end
        return pn;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    tcpu_state_s state_reg;
    tcpu_state_s state_next;

    logic [31:0] rdata;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [2:0] unit_sel;
    logic [TCPU_EVT_W-1:0] evt;
    logic [TCPU_EVT_W-1:0] clr;
    logic cap_edge;
    logic raw_i;
    logic do_write;
    tcpu_reg_e reg_sel;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        state_next = state_reg;
        rdata = TCPU_WORD_ZERO;
        wmask = tcpu_lane_mask(byteenable);
        wval = writedata & wmask;
        unit_sel = address[TCPU_UNIT_MSB:TCPU_UNIT_LSB];
        evt = TCPU_EVT_RST;
        clr = TCPU_EVT_RST;
        cap_edge = 1'b0;
        raw_i = 1'b0;
        do_write = write && !state_reg.wait_req;
        reg_sel = tcpu_decode(address);

        // Pins pass two flip-flops before any logic looks at them.
        state_next.kill_s1 = kill_in;
        state_next.kill_s2 = state_reg.kill_s1;
        state_next.cap_s1 = capture_in;
        state_next.cap_s2 = state_reg.cap_s1;
        state_next.cap_d = state_reg.cap_s2;

        for (int i = 0; i < TCPU_UNITS; i++) begin
            if (state_reg.ctrl[i][TCPU_CTRL_EN_BIT]) begin
                state_next.cnt[i] = tcpu_count_step(state_reg.cnt[i],
                    state_reg.period[i],
                    state_reg.ctrl[i][TCPU_CTRL_ONESHOT_BIT]);
                if (state_reg.cnt[i] == state_reg.period[i]) begin
                    evt[i] = 1'b1;
                    if (state_reg.ctrl[i][TCPU_CTRL_ONESHOT_BIT]) begin
                        state_next.ctrl[i][TCPU_CTRL_EN_BIT] = 1'b0;
                    end
                end
            end

            cap_edge = state_reg.cap_s2[i] && !state_reg.cap_d[i];
            if (state_reg.ctrl[i][TCPU_CTRL_CAPEN_BIT] && cap_edge) begin
                state_next.capture[i] = state_reg.cnt[i];
                evt[TCPU_EVT_CAP_BASE + i] = 1'b1;
            end

            raw_i = state_reg.ctrl[i][TCPU_CTRL_EN_BIT] &&
                    (state_reg.cnt[i] < state_reg.compare[i]);
            state_next.raw[i] = raw_i;
            // Both outputs sit low for the dead band after each edge so the
            // upper and lower switch never conduct together.
            state_next.dead_cnt[i] = tcpu_dead_step(
                raw_i != state_reg.raw[i], state_reg.dead_cnt[i],
                state_reg.dead_cfg[i]);

            {state_next.out_p[i], state_next.out_n[i]} = tcpu_drive(
                state_reg.kill_s2[i], raw_i,
                state_reg.ctrl[i][TCPU_CTRL_EN_BIT],
                state_next.dead_cnt[i]);
        end

        // Read data is gathered in the wait cycle and stands while the
        // master samples waitrequest low.
        case (reg_sel)
            TCPU_REG_STATUS: begin
                rdata[TCPU_EVT_W-1:0] = state_reg.irq_status;
            end
            TCPU_REG_MASK: begin
                rdata[TCPU_EVT_W-1:0] = state_reg.irq_mask;
            end
            TCPU_REG_CTRL: begin
                rdata[TCPU_CTRL_W-1:0] = state_reg.ctrl[unit_sel];
            end
            TCPU_REG_PERIOD: begin
                rdata[TCPU_CNT_W-1:0] = state_reg.period[unit_sel];
            end
            TCPU_REG_COMPARE: begin
                rdata[TCPU_CNT_W-1:0] = state_reg.compare[unit_sel];
            end
            TCPU_REG_DEADBAND: begin
                rdata[TCPU_DB_W-1:0] = state_reg.dead_cfg[unit_sel];
            end
            TCPU_REG_CAPTURE: begin
                rdata[TCPU_CNT_W-1:0] = state_reg.capture[unit_sel];
            end
            TCPU_REG_COUNT: begin
                rdata[TCPU_CNT_W-1:0] = state_reg.cnt[unit_sel];
            end
            default: begin
                rdata = TCPU_WORD_ZERO;
            end
        endcase

        if ((read || write) && state_reg.wait_req) begin
            state_next.wait_req = 1'b0;
            state_next.readdata = read ? rdata : TCPU_WORD_ZERO;
        end else if ((read || write) && !state_reg.wait_req) begin
            state_next.wait_req = 1'b1;
        end

        // Software writes come last so they override the hardware halt.
        if (do_write) begin
            case (reg_sel)
                TCPU_REG_STATUS: begin
                    clr = wval[TCPU_EVT_W-1:0];
                end
                TCPU_REG_MASK: begin
                    state_next.irq_mask = tcpu_merge16(state_reg.irq_mask,
                        writedata, wmask);
                end
                TCPU_REG_CTRL: begin
                    if (byteenable[0]) begin
                        state_next.ctrl[unit_sel] =
                            writedata[TCPU_CTRL_W-1:0];
                        // Enabling restarts the count so a stopped one-shot
                        // unit does not halt again at once.
                        if (writedata[TCPU_CTRL_EN_BIT]) begin
                            state_next.cnt[unit_sel] = TCPU_CNT_RST;
                        end
                    end
                end
                TCPU_REG_PERIOD: begin
                    state_next.period[unit_sel] = tcpu_merge16(
                        state_reg.period[unit_sel], writedata, wmask);
                end
                TCPU_REG_COMPARE: begin
                    state_next.compare[unit_sel] = tcpu_merge16(
                        state_reg.compare[unit_sel], writedata, wmask);
                end
                TCPU_REG_DEADBAND: begin
                    if (byteenable[0]) begin
                        state_next.dead_cfg[unit_sel] =
                            writedata[TCPU_DB_W-1:0];
                    end
                end
                // Capture and count are read-only; writes to them and to
                // unmapped addresses change nothing.
                default: begin
                    clr = TCPU_EVT_RST;
                end
            endcase
        end

        // A new event in the clearing cycle survives the clear.
        state_next.irq_status = (state_reg.irq_status & ~clr) | evt;
        state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < TCPU_UNITS; i++) begin
                state_reg.ctrl[i] <= TCPU_CTRL_RST;
                state_reg.period[i] <= TCPU_PERIOD_RST;
                state_reg.compare[i] <= TCPU_COMPARE_RST;
                state_reg.dead_cfg[i] <= TCPU_DB_RST;
                state_reg.cnt[i] <= TCPU_CNT_RST;
                state_reg.capture[i] <= TCPU_CNT_RST;
                state_reg.dead_cnt[i] <= TCPU_DB_RST;
            end
            state_reg.raw <= '0;
            state_reg.out_p <= '0;
            state_reg.out_n <= '0;
            state_reg.kill_s1 <= '0;
            state_reg.kill_s2 <= '0;
            state_reg.cap_s1 <= '0;
            state_reg.cap_s2 <= '0;
            state_reg.cap_d <= '0;
            state_reg.irq_status <= TCPU_EVT_RST;
            state_reg.irq_mask <= TCPU_EVT_RST;
            state_reg.irq <= 1'b0;
            state_reg.wait_req <= 1'b1;
            state_reg.readdata <= TCPU_WORD_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    assign readdata = state_reg.readdata;
    assign waitrequest = state_reg.wait_req;
    assign pwm_out = state_reg.out_p;
    assign pwm_n_out = state_reg.out_n;
    assign irq = state_reg.irq;
endmodule
`default_nettype wire

// ==== bench/tcpu_top_assertions.sv ====
// Purpose: Port-level checker for the timer/counter/PWM array.
// Assumes: One wait cycle per bus access, kill level 0 on both outputs.
// Notes: Sees only the top ports; attached by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module tcpu_top_chk (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [tcpu_pkg::TCPU_UNITS-1:0] kill_in,
    input wire logic [tcpu_pkg::TCPU_UNITS-1:0] pwm_out,
    input wire logic [tcpu_pkg::TCPU_UNITS-1:0] pwm_n_out,
    input wire logic irq
);
    import tcpu_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Outputs must stay quiet until software has written something.
    logic wrote_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) wrote_reg <= 1'b0;
        else if (write && !waitrequest) wrote_reg <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    wait_one_a: assert property ((read || write) && waitrequest |=>
        !waitrequest)
        else $error("access not answered after one wait cycle");
    wait_short_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    wait_idle_a: assert property (!read && !write && waitrequest |=>
        waitrequest)
        else $error("answer without a request");
    wait_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
        else $error("waitrequest fell with no request pending");
    wdata_zero_a: assert property (write && !waitrequest |-> readdata == 32'h0)
        else $error("readdata not zero on write completion");
    rdata_stable_a: assert property ($changed(readdata) |-> !waitrequest)
        else $error("readdata changed outside a completion");
    no_overlap_a: assert property ((pwm_out & pwm_n_out) == 8'h00)
        else $error("true and complementary outputs high together");
    kill_safe_a: assert property ((kill_in == 8'hFF) [*3] |=>
        pwm_out == 8'h00 && pwm_n_out == 8'h00)
        else $error("outputs not forced low under kill");
    reset_quiet_a: assert property (!wrote_reg |->
        pwm_out == 8'h00 && pwm_n_out == 8'h00 && irq == 1'b0)
        else $error("outputs active before any write");
    cover property (read && !waitrequest);
    cover property ((kill_in == 8'hFF) && pwm_n_out != 8'h00);
    cover property ($rose(irq));
endmodule
bind tcpu_top tcpu_top_chk i_chk (.core_clk(core_clk), .arst_n(arst_n),
    .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .kill_in(kill_in), .pwm_out(pwm_out),
    .pwm_n_out(pwm_n_out), .irq(irq));
`default_nettype wire

// ==== bench/tcpu_gate_model.sv ====
// Purpose: Gate driver and event pin model facing the PWM outputs.
// Assumes: Pins change only on core_clk edges here.
// Notes: Measures rise-to-rise period and fall-to-rise gap of one unit.
`timescale 1ns/10ps
`default_nettype none
module tcpu_gate_model (
    input wire logic core_clk,
    input wire logic [7:0] kill_req,
    input wire logic [7:0] cap_req,
    input wire logic [2:0] sel,
    input wire logic [7:0] pwm_out,
    input wire logic [7:0] pwm_n_out,
    output logic [7:0] kill_in,
    output logic [7:0] capture_in,
    output logic [15:0] period_seen,
    output logic [15:0] gap_seen
);
    logic [15:0] since_rise = 16'h0000;
    logic [15:0] since_fall = 16'h0000;
    logic p_d = 1'b0;
    logic n_d = 1'b0;
    always_ff @(posedge core_clk) begin
        kill_in <= kill_req;
        capture_in <= cap_req;
        p_d <= pwm_out[sel];
        n_d <= pwm_n_out[sel];
        since_rise <= since_rise + 16'h0001;
        since_fall <= since_fall + 16'h0001;
        if (pwm_out[sel] && !p_d) begin
            period_seen <= since_rise + 16'h0001;
            since_rise <= 16'h0000;
        end
        if (!pwm_out[sel] && p_d) since_fall <= 16'h0000;
        if (pwm_n_out[sel] && !n_d) gap_seen <= since_fall + 16'h0001;
    end
endmodule
`default_nettype wire

// ==== bench/tcpu_top_test.sv ====
// Purpose: Self-checking bench for the timer/counter/PWM array.
// Assumes: Random values from a fixed seed; all pins via the gate model.
// Notes: Timing is measured in the model, so reads need no exact cycle.
`timescale 1ns/10ps
`default_nettype none
module tcpu_top_test;
    import tcpu_pkg::*;
    logic core_clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic [8:0] address = 9'h000;
    logic [31:0] writedata = 32'h0, readdata, rdat, c1, cap;
    logic waitrequest, irq;
    logic [7:0] kill_in, capture_in, pwm_out, pwm_n_out;
    logic [7:0] kill_req = 8'h00, cap_req = 8'h00;
    logic [2:0] sel = 3'h0;
    logic [15:0] period_seen, gap_seen, p, d;
    int err_total = 0, cmp_count = 0, u, v, w;
    always #12.5 core_clk = ~core_clk;
    tcpu_top i_dut (.core_clk(core_clk), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .kill_in(kill_in), .capture_in(capture_in), .pwm_out(pwm_out),
        .pwm_n_out(pwm_n_out), .irq(irq));
    tcpu_gate_model i_pins (.core_clk(core_clk), .kill_req(kill_req),
        .cap_req(cap_req), .sel(sel), .pwm_out(pwm_out),
        .pwm_n_out(pwm_n_out), .kill_in(kill_in), .capture_in(capture_in),
        .period_seen(period_seen), .gap_seen(gap_seen));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] ua(input int n, input logic [4:0] o);
        return {1'b0, n[2:0], o};
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [8:0] a,
        input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge core_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= dat;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_total++;
            results();
        end else begin
            rdat = readdata;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(69005));
        tick(3);
        arst_n <= 1'b1;
        for (int n = 0; n < TCPU_UNITS; n++) begin
            bus(0, ua(n, TCPU_OFS_PERIOD), 0); check("period", rdat, 32'hFFFF);
            bus(0, ua(n, TCPU_OFS_CTRL), 0); check("ctrl", rdat, 32'h0);
            bus(0, ua(n, TCPU_OFS_COUNT), 0); check("count", rdat, 32'h0);
        end
        check("outputs", {pwm_out, pwm_n_out}, 32'h0);
        bus(0, ua(0, 5'h18), 0); check("unmapped", rdat, 32'h0);
        bus(1, ua(1, TCPU_OFS_COUNT), 32'h1234);
        bus(0, ua(1, TCPU_OFS_COUNT), 0); check("count ro", rdat, 32'h0);
        u = $urandom % 8;
        p = 16'd5 + 16'($urandom % 20);
        bus(1, ua(u, TCPU_OFS_PERIOD), p);
        bus(0, ua((u + 1) % 8, TCPU_OFS_PERIOD), 0); check("own", rdat, 32'hFFFF);
        bus(1, TCPU_ADDR_IRQ_MASK, 32'h1 << u);
        bus(1, ua(u, TCPU_OFS_CTRL), 32'h3);
        tick(p + 10);
        bus(0, ua(u, TCPU_OFS_COUNT), 0); check("halt count", rdat, p);
        bus(0, ua(u, TCPU_OFS_CTRL), 0); check("halt ctrl", rdat, 32'h2);
        bus(0, TCPU_ADDR_IRQ_STATUS, 0); check("status", rdat, 32'h1 << u);
        check("irq on", irq, 1'b1);
        bus(1, TCPU_ADDR_IRQ_MASK, 0);
        tick(2); check("irq masked", irq, 1'b0);
        bus(1, TCPU_ADDR_IRQ_MASK, 32'h1 << u);
        tick(2); check("irq unmasked", irq, 1'b1);
        bus(1, TCPU_ADDR_IRQ_STATUS, 32'h1 << u);
        tick(2); check("irq cleared", irq, 1'b0);
        v = $urandom % 8;
        sel <= v[2:0];
        p = 16'd40 + 16'($urandom % 20);
        d = 16'd2 + 16'($urandom % 4);
        bus(1, ua(v, TCPU_OFS_PERIOD), p);
        bus(1, ua(v, TCPU_OFS_COMPARE), p >> 1);
        bus(1, ua(v, TCPU_OFS_DEADBAND), d);
        bus(1, ua(v, TCPU_OFS_CTRL), 32'h1);
        tick(3 * (p + 1));
        check("pwm period", period_seen, p + 16'd1);
        check("dead gap", gap_seen >= d && gap_seen <= d + 16'd2, 1'b1);
        kill_req <= 8'hFF;
        tick(6); check("kill", {pwm_out, pwm_n_out}, 32'h0);
        kill_req <= 8'h00;
        w = (v + 1) % 8;
        bus(1, ua(w, TCPU_OFS_PERIOD), 32'hFFFF);
        bus(1, ua(w, TCPU_OFS_CTRL), 32'h5);
        tick(20);
        bus(0, ua(w, TCPU_OFS_COUNT), 0);
        c1 = rdat;
        cap_req[w] <= 1'b1;
        tick(6);
        cap_req[w] <= 1'b0;
        bus(0, ua(w, TCPU_OFS_CAPTURE), 0);
        cap = rdat;
        bus(0, ua(w, TCPU_OFS_COUNT), 0);
        check("capture", c1 < cap && cap < rdat, 1'b1);
        bus(0, TCPU_ADDR_IRQ_STATUS, 0);
        check("cap status", rdat[8 + w], 1'b1);
        tick(3 * (p + 1));
        check("resume", period_seen, p + 16'd1);
        results();
    end
endmodule
`default_nettype wire
